// ---- cfg_param_pkg.sv ----
// Package: offsets, field layouts, reset values and codes of the adapter parameter bank
package cfg_param_pkg;

  // ==========================================================================
  // Register indices (parameter numbers); byte address is four times the index
  localparam logic [7:0] IDX_ADAPTER_TYPE   = 8'h01;
  localparam logic [7:0] IDX_PROFILE        = 8'h02;
  localparam logic [7:0] IDX_NODE_ADDR      = 8'h03;
  localparam logic [7:0] IDX_BAUD           = 8'h04;
  localparam logic [7:0] IDX_PARITY         = 8'h05;
  localparam logic [7:0] IDX_PROTOCOL       = 8'h19;
  localparam logic [7:0] IDX_CONTROL        = 8'h20;
  localparam logic [7:0] IDX_STATUS         = 8'h21;
  localparam logic [7:0] IDX_ACTIVE_PROFILE = 8'h22;
  localparam logic [7:0] IDX_ACTIVE_ADDR    = 8'h23;
  localparam logic [7:0] IDX_ACTIVE_BAUD    = 8'h24;
  localparam logic [7:0] IDX_ACTIVE_PARITY  = 8'h25;
  localparam logic [7:0] IDX_ACTIVE_PROTO   = 8'h26;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int PAR_W  = 16;

  // ==========================================================================
  // Reset values and ranges
  localparam logic [15:0] ADAPTER_TYPE_NONE  = 16'h0000;
  // Detected-type code, arbitrary neutral value
  localparam logic [15:0] ADAPTER_TYPE_CODE  = 16'h00A5;
  localparam logic [15:0] PROFILE_RESET      = 16'h0000;
  localparam logic [15:0] PROFILE_MAX        = 16'h0003;
  localparam logic [15:0] NODE_ADDR_RESET    = 16'h0001;
  localparam logic [15:0] NODE_ADDR_MIN      = 16'h0001;
  localparam logic [15:0] NODE_ADDR_MAX      = 16'h00F7;
  localparam logic [15:0] BAUD_RESET         = 16'h0000;
  localparam logic [15:0] BAUD_MAX           = 16'h0004;
  localparam logic [15:0] PARITY_RESET       = 16'h0000;
  localparam logic [15:0] PARITY_MAX         = 16'h0003;
  localparam logic [15:0] PROTOCOL_RESET     = 16'h0000;

  // ==========================================================================
  // Control and status bit positions
  localparam int CTRL_REFRESH_BIT = 0;
  localparam int STAT_LINK_BIT    = 0;
  localparam int STAT_COPY_BIT    = 1;
  localparam int STAT_PEND_BIT    = 2;

  // Copy-to-drive walks indices 1..5 and the protocol word
  localparam int NUM_COPY = 6;

  // ==========================================================================
  // Codes
  typedef enum logic [1:0] {
    CLASSIC_DRIVE_PROFILE  = 2'd0,
    ENHANCED_DRIVE_PROFILE = 2'd1,
    TRANSP_16_PROFILE      = 2'd2,
    TRANSP_32_PROFILE      = 2'd3
  } profile_t;

  typedef enum logic [2:0] {
    BAUD_9K6   = 3'd0,
    BAUD_19K2  = 3'd1,
    BAUD_38K4  = 3'd2,
    BAUD_57K6  = 3'd3,
    BAUD_115K2 = 3'd4
  } baud_t;

  typedef enum logic [1:0] {
    FMT_8N1 = 2'd0,
    FMT_8N2 = 2'd1,
    FMT_8E1 = 2'd2,
    FMT_8O1 = 2'd3
  } parity_t;

  typedef enum logic [2:0] {
    ST_WAIT_LINK = 3'b001,
    ST_COPY      = 3'b010,
    ST_RUN       = 3'b100
  } copy_state_t;

  // Active link settings as one carrier
  typedef struct packed {
    profile_t    profile;
    logic [7:0]  node_addr;
    baud_t       baud;
    parity_t     parity;
    logic [15:0] protocol;
  } link_cfg_t;

  // Frame format decoded from the parity code
  typedef struct packed {
    logic parity_en;
    logic parity_odd;
    logic two_stop;
  } frame_fmt_t;

  // Word pushed to the drive during the copy
  typedef struct packed {
    logic [7:0]  index;
    logic [15:0] value;
  } copy_word_t;

endpackage

// ---- cfg_param_store.sv ----
// Small parameter memory: the copy of the settings held for the drive, registered read
`timescale 1ns/1ps
`default_nettype none
module cfg_param_store
  import cfg_param_pkg::*;
(
  input  wire logic             mclk_in,   // Clock
  input  wire logic             resetn_in, // Async reset, active low
  input  wire logic             wr_en_in,  // Write enable
  input  wire logic [2:0]       wr_addr_in,// Write slot
  input  wire logic [PAR_W-1:0] wr_data_in,// Write value
  input  wire logic [2:0]       rd_addr_in,// Read slot
  output logic      [PAR_W-1:0] rd_data_out// Registered read value
);

  logic [PAR_W-1:0] mem_reg [NUM_COPY];

  always_ff @(posedge mclk_in) begin
    if (wr_en_in && (wr_addr_in < 3'(NUM_COPY))) begin
      mem_reg[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_data_out <= 16'h0000;
    end else if (rd_addr_in < 3'(NUM_COPY)) begin
      rd_data_out <= mem_reg[rd_addr_in];
    end else begin
      rd_data_out <= 16'h0000;
    end
  end

endmodule
`default_nettype wire

// ---- serial_adapter_config_params.sv ----
// Configuration parameter bank of a serial fieldbus adapter with apply-on-refresh
`timescale 1ns/1ps
`default_nettype none
module serial_adapter_config_params
  import cfg_param_pkg::*;
(
  input  wire logic              mclk_in,         // 10 MHz clock
  input  wire logic              resetn_in,       // Async reset, active low
  input  wire logic [ADDR_W-1:0] addr_in,         // Byte address
  input  wire logic [DATA_W-1:0] wdata_in,        // Write data
  input  wire logic              wr_in,           // Write strobe
  input  wire logic              rd_in,           // Read strobe
  output logic      [DATA_W-1:0] rdata_out,       // Read data, cycle after strobe
  input  wire logic              link_up_in,      // Drive link established (pin)
  output logic                   copy_valid_out,  // Copy word strobe to drive
  output var copy_word_t         copy_word_out,   // Index and value copied
  output var link_cfg_t          active_cfg_out,  // Settings in force
  output var frame_fmt_t         frame_fmt_out    // Decoded frame format
);

  // ==========================================================================
  // Decode helpers
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    return a == {idx, 2'b00};
  endfunction

  function automatic frame_fmt_t fmt_of(input parity_t p);
    frame_fmt_t f;
    f = '{parity_en: 1'b0, parity_odd: 1'b0, two_stop: 1'b0};
    case (p)
      FMT_8N2: f.two_stop   = 1'b1;
      FMT_8E1: f.parity_en  = 1'b1;
      FMT_8O1: begin
        f.parity_en  = 1'b1;
        f.parity_odd = 1'b1;
      end
      default: f = f;
    endcase
    return f;
  endfunction

  // ==========================================================================
  // Link-up synchroniser; only the second stage is used
  logic link_meta_reg;
  logic link_sync_reg;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      link_meta_reg <= 1'b0;
      link_sync_reg <= 1'b0;
    end else begin
      link_meta_reg <= link_up_in;
      link_sync_reg <= link_meta_reg;
    end
  end

  // ==========================================================================
  // Pending (written) parameters
  logic [15:0] profile_reg;
  logic [15:0] node_addr_reg;
  logic [15:0] baud_reg;
  logic [15:0] parity_reg;
  logic [15:0] protocol_reg;
  logic        pending_reg;
  logic [15:0] wval;

  assign wval = wdata_in[15:0];

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      profile_reg   <= PROFILE_RESET;
      node_addr_reg <= NODE_ADDR_RESET;
      baud_reg      <= BAUD_RESET;
      parity_reg    <= PARITY_RESET;
      protocol_reg  <= PROTOCOL_RESET;
    end else if (wr_in) begin
      // Out-of-range codes are dropped so a bad write cannot wedge the link
      if (hit(addr_in, IDX_PROFILE) && wval <= PROFILE_MAX) begin
        profile_reg <= wval;
      end
      if (hit(addr_in, IDX_NODE_ADDR) && wval >= NODE_ADDR_MIN && wval <= NODE_ADDR_MAX) begin
        node_addr_reg <= wval;
      end
      if (hit(addr_in, IDX_BAUD) && wval <= BAUD_MAX) begin
        baud_reg <= wval;
      end
      if (hit(addr_in, IDX_PARITY) && wval <= PARITY_MAX) begin
        parity_reg <= wval;
      end
      if (hit(addr_in, IDX_PROTOCOL)) begin
        protocol_reg <= wval;
      end
    end
  end

  logic any_cfg_wr;
  logic refresh_wr;

  assign any_cfg_wr = wr_in && (hit(addr_in, IDX_PROFILE) || hit(addr_in, IDX_NODE_ADDR) ||
                      hit(addr_in, IDX_BAUD) || hit(addr_in, IDX_PARITY) ||
                      hit(addr_in, IDX_PROTOCOL));
  assign refresh_wr = wr_in && hit(addr_in, IDX_CONTROL) && wdata_in[CTRL_REFRESH_BIT];

  // ==========================================================================
  // Apply: active settings change only on refresh (reset gives the defaults)
  logic apply_reg;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      apply_reg <= 1'b0;
    end else begin
      apply_reg <= refresh_wr;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      active_cfg_out <= '{profile: CLASSIC_DRIVE_PROFILE, node_addr: NODE_ADDR_RESET[7:0],
                          baud: BAUD_9K6, parity: FMT_8N1, protocol: PROTOCOL_RESET};
      frame_fmt_out  <= '{parity_en: 1'b0, parity_odd: 1'b0, two_stop: 1'b0};
    end else if (apply_reg) begin
      active_cfg_out.profile   <= profile_t'(profile_reg[1:0]);
      active_cfg_out.node_addr <= node_addr_reg[7:0];
      active_cfg_out.baud      <= baud_t'(baud_reg[2:0]);
      active_cfg_out.parity    <= parity_t'(parity_reg[1:0]);
      active_cfg_out.protocol  <= protocol_reg;
      frame_fmt_out            <= fmt_of(parity_t'(parity_reg[1:0]));
    end
  end

  // Pending flag: a new write wins over the apply that would clear it
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pending_reg <= 1'b0;
    end else if (any_cfg_wr) begin
      pending_reg <= 1'b1;
    end else if (apply_reg) begin
      pending_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Copy to drive after link-up
  copy_state_t state_reg;
  logic [2:0]  copy_cnt_reg;
  logic        copy_rd_reg;
  logic [2:0]  copy_slot_reg;
  logic [2:0]  store_waddr;
  logic [15:0] store_wdata;
  logic [15:0] store_rdata;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg    <= ST_WAIT_LINK;
      copy_cnt_reg <= 3'd0;
    end else begin
      case (state_reg)
        ST_WAIT_LINK: begin
          copy_cnt_reg <= 3'd0;
          if (link_sync_reg) begin
            state_reg <= ST_COPY;
          end
        end
        ST_COPY: begin
          if (copy_cnt_reg == 3'(NUM_COPY - 1)) begin
            state_reg <= ST_RUN;
          end
          copy_cnt_reg <= copy_cnt_reg + 3'd1;
        end
        ST_RUN: begin
          if (!link_sync_reg) begin
            state_reg <= ST_WAIT_LINK;
          end
        end
        default: state_reg <= ST_WAIT_LINK;
      endcase
    end
  end

  // Store mirrors the type code and the five written parameters; it is refreshed continuously round-robin
  logic [2:0] mirror_reg;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mirror_reg <= 3'd0;
    end else begin
      mirror_reg <= (mirror_reg == 3'(NUM_COPY - 1)) ? 3'd0 : mirror_reg + 3'd1;
    end
  end

  always_comb begin
    store_waddr = mirror_reg;
    case (mirror_reg)
      3'd0:    store_wdata = ADAPTER_TYPE_CODE;
      3'd1:    store_wdata = profile_reg;
      3'd2:    store_wdata = node_addr_reg;
      3'd3:    store_wdata = baud_reg;
      3'd4:    store_wdata = parity_reg;
      default: store_wdata = protocol_reg;
    endcase
  end

  cfg_param_store cfg_param_store_i (
    .mclk_in     (mclk_in),
    .resetn_in   (resetn_in),
    .wr_en_in    (1'b1),
    .wr_addr_in  (store_waddr),
    .wr_data_in  (store_wdata),
    .rd_addr_in  (copy_cnt_reg),
    .rd_data_out (store_rdata)
  );

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      copy_rd_reg   <= 1'b0;
      copy_slot_reg <= 3'd0;
    end else begin
      copy_rd_reg   <= (state_reg == ST_COPY);
      copy_slot_reg <= copy_cnt_reg;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      copy_valid_out <= 1'b0;
      copy_word_out  <= '{index: 8'h00, value: 16'h0000};
    end else begin
      copy_valid_out <= copy_rd_reg;
      copy_word_out.index <= (copy_slot_reg == 3'(NUM_COPY - 1)) ? IDX_PROTOCOL
                                                                : 8'(copy_slot_reg) + 8'h01;
      copy_word_out.value <= store_rdata;
    end
  end

  // ==========================================================================
  // Read path; type shows zero until link is up, writes never reach it
  logic [15:0] type_val;

  assign type_val = link_sync_reg ? ADAPTER_TYPE_CODE : ADAPTER_TYPE_NONE;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_out <= 32'h0000_0000;
    end else if (rd_in) begin
      case (1'b1)
        hit(addr_in, IDX_ADAPTER_TYPE):   rdata_out <= {16'h0000, type_val};
        hit(addr_in, IDX_PROFILE):        rdata_out <= {16'h0000, profile_reg};
        hit(addr_in, IDX_NODE_ADDR):      rdata_out <= {16'h0000, node_addr_reg};
        hit(addr_in, IDX_BAUD):           rdata_out <= {16'h0000, baud_reg};
        hit(addr_in, IDX_PARITY):         rdata_out <= {16'h0000, parity_reg};
        hit(addr_in, IDX_PROTOCOL):       rdata_out <= {16'h0000, protocol_reg};
        hit(addr_in, IDX_STATUS): begin
          rdata_out <= 32'h0000_0000;
          rdata_out[STAT_LINK_BIT] <= link_sync_reg;
          rdata_out[STAT_COPY_BIT] <= (state_reg == ST_RUN);
          rdata_out[STAT_PEND_BIT] <= pending_reg;
        end
        hit(addr_in, IDX_ACTIVE_PROFILE): rdata_out <= {30'h0, active_cfg_out.profile};
        hit(addr_in, IDX_ACTIVE_ADDR):    rdata_out <= {24'h0, active_cfg_out.node_addr};
        hit(addr_in, IDX_ACTIVE_BAUD):    rdata_out <= {29'h0, active_cfg_out.baud};
        hit(addr_in, IDX_ACTIVE_PARITY):  rdata_out <= {30'h0, active_cfg_out.parity};
        hit(addr_in, IDX_ACTIVE_PROTO):   rdata_out <= {16'h0000, active_cfg_out.protocol};
        default:                          rdata_out <= 32'h0000_0000;
      endcase
    end else begin
      rdata_out <= 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Checks
  property p_type_zero;
    @(posedge mclk_in) disable iff (!resetn_in)
    rd_in && hit(addr_in, IDX_ADAPTER_TYPE) && !link_sync_reg |=> rdata_out == 32'h0000_0000;
  endproperty
  a_type_zero: assert property (p_type_zero) else $error("type nonzero without link");

  property p_type_ro;
    @(posedge mclk_in) disable iff (!resetn_in)
    rd_in && hit(addr_in, IDX_ADAPTER_TYPE) && link_sync_reg |=>
      rdata_out[15:0] == ADAPTER_TYPE_CODE;
  endproperty
  a_type_ro: assert property (p_type_ro) else $error("type register altered");

  property p_profile_range;
    @(posedge mclk_in) disable iff (!resetn_in)
    profile_reg <= PROFILE_MAX;
  endproperty
  a_profile_range: assert property (p_profile_range) else $error("profile out of range");

  property p_proto_sep;
    @(posedge mclk_in) disable iff (!resetn_in)
    wr_in && hit(addr_in, IDX_PROTOCOL) |=> $stable(profile_reg) && protocol_reg == $past(wval);
  endproperty
  a_proto_sep: assert property (p_proto_sep) else $error("protocol write wrong");

  property p_addr_range;
    @(posedge mclk_in) disable iff (!resetn_in)
    node_addr_reg >= NODE_ADDR_MIN && node_addr_reg <= NODE_ADDR_MAX;
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("address out of range");

  property p_baud_range;
    @(posedge mclk_in) disable iff (!resetn_in)
    baud_reg <= BAUD_MAX;
  endproperty
  a_baud_range: assert property (p_baud_range) else $error("baud out of range");

  property p_copy_burst;
    @(posedge mclk_in) disable iff (!resetn_in)
    $rose(state_reg == ST_COPY) |-> ##2 copy_valid_out [*6] ##1 !copy_valid_out;
  endproperty
  a_copy_burst: assert property (p_copy_burst) else $error("copy burst wrong length");

  property p_no_early_apply;
    @(posedge mclk_in) disable iff (!resetn_in)
    !apply_reg |=> $stable(active_cfg_out);
  endproperty
  a_no_early_apply: assert property (p_no_early_apply) else $error("settings changed early");

  property p_apply;
    @(posedge mclk_in) disable iff (!resetn_in)
    refresh_wr ##1 !wr_in |=> active_cfg_out.node_addr == node_addr_reg[7:0];
  endproperty
  a_apply: assert property (p_apply) else $error("refresh not applied");

  property p_parity_fmt;
    @(posedge mclk_in) disable iff (!resetn_in)
    frame_fmt_out.parity_en == active_cfg_out.parity[1] &&
    frame_fmt_out.two_stop == (active_cfg_out.parity == FMT_8N2);
  endproperty
  a_parity_fmt: assert property (p_parity_fmt) else $error("frame format mismatch");

endmodule
`default_nettype wire

// ---- drive_link_model.sv ----
// Drive-side model: raises the adapter link and collects the copied parameter words
`timescale 1ns/1ps
`default_nettype none
module drive_link_model
  import cfg_param_pkg::*;
(
  input  wire logic       mclk_in,       // Clock
  input  wire logic       resetn_in,     // Async reset, active low
  input  wire logic       copy_valid_in, // Copy word strobe from adapter
  input  wire copy_word_t copy_word_in,  // Copied index and value
  output logic            link_up_out    // Link established level
);
  copy_word_t words [8];
  int         n_words;

  initial link_up_out = 1'b0;

  // ==========================================================================
  // Link control, changed right after an edge like any other driver
  task automatic set_link(input logic up);
    @(posedge mclk_in);
    link_up_out <= up;
  endtask

  // ==========================================================================
  // Collection of the copied set; words past eight are counted, not stored
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      n_words <= 0;
    end else if (copy_valid_in) begin
      if (n_words < 8) begin
        words[n_words] <= copy_word_in;
      end
      n_words <= n_words + 1;
    end
  end
endmodule
`default_nettype wire

// ---- serial_adapter_config_params_tb.sv ----
// Self-checking testbench of the adapter parameter bank
`timescale 1ns/1ps
`default_nettype none
module serial_adapter_config_params_tb;
  import cfg_param_pkg::*;

  logic              mclk_in = 1'b0;
  logic              resetn_in = 1'b0;
  logic [ADDR_W-1:0] addr_in = '0;
  logic [DATA_W-1:0] wdata_in = '0;
  logic              wr_in = 1'b0;
  logic              rd_in = 1'b0;
  logic [DATA_W-1:0] rdata_out;
  logic              link_up_in;
  logic              copy_valid_out;
  copy_word_t        copy_word_out;
  link_cfg_t         active_cfg_out;
  frame_fmt_t        frame_fmt_out;
  int                mismatches = 0;
  int                n_checks = 0;
  logic [7:0]        exp_idx [6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h19};
  logic [15:0]       exp_val [6] = '{ADAPTER_TYPE_CODE, 16'h0002, 16'h00F7, 16'h0004, 16'h0003,
                                     16'h0001};

  initial begin
    forever #50 mclk_in = ~mclk_in;
  end

  serial_adapter_config_params serial_adapter_config_params_i (
    .mclk_in        (mclk_in),
    .resetn_in      (resetn_in),
    .addr_in        (addr_in),
    .wdata_in       (wdata_in),
    .wr_in          (wr_in),
    .rd_in          (rd_in),
    .rdata_out      (rdata_out),
    .link_up_in     (link_up_in),
    .copy_valid_out (copy_valid_out),
    .copy_word_out  (copy_word_out),
    .active_cfg_out (active_cfg_out),
    .frame_fmt_out  (frame_fmt_out)
  );

  drive_link_model drive_link_model_i (
    .mclk_in       (mclk_in),
    .resetn_in     (resetn_in),
    .copy_valid_in (copy_valid_out),
    .copy_word_in  (copy_word_out),
    .link_up_out   (link_up_in)
  );

  // ==========================================================================
  // Checking and closing
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // Register bus: one-cycle strobes, read data taken in the cycle after
  task automatic wr_reg(input logic [7:0] idx, input logic [15:0] val);
    @(posedge mclk_in);
    wr_in    <= 1'b1;
    addr_in  <= {idx, 2'b00};
    wdata_in <= {16'h0000, val};
    @(posedge mclk_in);
    wr_in    <= 1'b0;
  endtask

  task automatic rd_check(input string what, input logic [7:0] idx, input logic [31:0] exp);
    @(posedge mclk_in);
    rd_in   <= 1'b1;
    addr_in <= {idx, 2'b00};
    @(posedge mclk_in);
    rd_in   <= 1'b0;
    #1;
    check(what, rdata_out, exp);
  endtask

  // Writes codes 0..n_legal; the last one is out of range and must leave n_legal-1
  task automatic sweep(input string what, input logic [7:0] idx, input int n_legal);
    for (int i = 0; i <= n_legal; i++) begin
      wr_reg(idx, 16'(i));
      rd_check(what, idx, (i < n_legal) ? 32'(i) : 32'(n_legal - 1));
    end
  endtask

  // ==========================================================================
  // Main sequence; a single station on the network, so no address clash
  initial begin
    repeat (16) @(posedge mclk_in);
    resetn_in <= 1'b1;
    rd_check("profile default", IDX_PROFILE, 32'h0000_0000);
    rd_check("address default", IDX_NODE_ADDR, 32'h0000_0001);
    rd_check("baud default", IDX_BAUD, 32'h0000_0000);
    rd_check("type while link down", IDX_ADAPTER_TYPE, 32'h0000_0000);
    wr_reg(IDX_ADAPTER_TYPE, 16'h1234);
    rd_check("type after write", IDX_ADAPTER_TYPE, 32'h0000_0000);
    wr_reg(8'hFC, 16'h5A5A);
    rd_check("unmapped read", 8'hFC, 32'h0000_0000);
    sweep("profile code", IDX_PROFILE, 4);
    sweep("baud code", IDX_BAUD, 5);
    sweep("parity code", IDX_PARITY, 4);
    wr_reg(IDX_NODE_ADDR, 16'h00F7);
    wr_reg(IDX_NODE_ADDR, 16'h0000);
    rd_check("address zero refused", IDX_NODE_ADDR, 32'h0000_00F7);
    wr_reg(IDX_NODE_ADDR, 16'h00F8);
    rd_check("address 248 refused", IDX_NODE_ADDR, 32'h0000_00F7);
    wr_reg(IDX_PROFILE, 16'h0002);
    wr_reg(IDX_PROTOCOL, 16'h0001);
    rd_check("protocol", IDX_PROTOCOL, 32'h0000_0001);
    rd_check("profile beside protocol", IDX_PROFILE, 32'h0000_0002);
    // Nothing applied yet: settings in force are still the reset ones
    check("active before refresh", {1'b0, active_cfg_out}, 32'h0020_0000);
    rd_check("status pending", IDX_STATUS, 32'h0000_0004);
    rd_check("active address", IDX_ACTIVE_ADDR, 32'h0000_0001);
    check("frame before refresh", {29'h0, frame_fmt_out}, 32'h0000_0000);
    wr_reg(IDX_CONTROL, 16'h0001);
    repeat (3) @(posedge mclk_in);
    #1;
    check("active after refresh", {1'b0, active_cfg_out}, {1'b0, 2'd2, 8'hF7, 3'd4, 2'd3, 16'h0001});
    check("frame odd parity", {29'h0, frame_fmt_out}, 32'h0000_0006);
    rd_check("active baud", IDX_ACTIVE_BAUD, 32'h0000_0004);
    // Bring the drive link up and collect the copied set
    drive_link_model_i.set_link(1'b1);
    for (int t = 0; t < 60 && drive_link_model_i.n_words < 6; t++) begin
      @(posedge mclk_in);
    end
    if (drive_link_model_i.n_words < 6) begin
      // Copy never finished: counted as a mismatch, straight to the verdict
      mismatches++;
    end else begin
      repeat (4) @(posedge mclk_in);
      check("copy count", 32'(drive_link_model_i.n_words), 32'd6);
      for (int i = 0; i < 6; i++) begin
        check("copy index", {24'h0, drive_link_model_i.words[i].index}, {24'h0, exp_idx[i]});
        check("copy value", {16'h0, drive_link_model_i.words[i].value}, {16'h0, exp_val[i]});
      end
      rd_check("status after copy", IDX_STATUS, 32'h0000_0003);
      rd_check("type with link", IDX_ADAPTER_TYPE, {16'h0, ADAPTER_TYPE_CODE});
      wr_reg(IDX_ADAPTER_TYPE, 16'h0000);
      rd_check("type write with link", IDX_ADAPTER_TYPE, {16'h0, ADAPTER_TYPE_CODE});
      drive_link_model_i.set_link(1'b0);
      repeat (5) @(posedge mclk_in);
      rd_check("type after link drop", IDX_ADAPTER_TYPE, 32'h0000_0000);
      check("active held", {1'b0, active_cfg_out}, {1'b0, 2'd2, 8'hF7, 3'd4, 2'd3, 16'h0001});
    end
    give_verdict();
  end
endmodule
`default_nettype wire
